/* File: shared/bcp_pkg.sv */
package bcp_pkg;

	typedef logic [1:0] bcp_width_t;

	localparam bcp_width_t BCP_WIDTH_8  = 2'h0;
	localparam bcp_width_t BCP_WIDTH_16 = 2'h1;
	localparam bcp_width_t BCP_WIDTH_32 = 2'h2;

	// chip-select region codes
	localparam logic [2:0] BCP_REGION_BOOT = 3'h0;
	localparam logic [2:0] BCP_REGION_LAST = 3'h5;

	// gap lengths in bus clocks
	localparam int         BCP_IDLE_CLKS  = 2;
	localparam int         BCP_ADDR_CLKS  = 1;
	localparam logic [1:0] BCP_IDLE_LOAD  = 2'(BCP_IDLE_CLKS - 1);

	// strap capture: the straps pass a two-stage synchroniser first
	localparam int         BCP_SYNC_STAGES = 2;
	localparam logic [1:0] BCP_STRAP_TAKE  = 2'(BCP_SYNC_STAGES);
	localparam logic [1:0] BCP_STRAP_DONE  = 2'h3;

	// bit positions in the cache and bus-interface control word
	localparam int BCP_CBI_CACHE_EN_BIT = 7;
	localparam int BCP_CBI_NC_WAIT_LSB  = 8;

	// reset values
	localparam bcp_width_t BCP_BOOT_WIDTH_RST = BCP_WIDTH_32;
	localparam logic       BCP_SYNC_HIGH_RST  = 1'h1;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic       fetch;
		logic [2:0] region;
		logic       internal_cacheable;
	} bcp_req_t;

	typedef struct packed {
		logic       cache_enable;
		logic [1:0] nc_wait;
		logic       internal_sel;
	} bcp_cache_ctrl_t;

	typedef bcp_width_t [5:1] bcp_region_widths_t;

endpackage

/* File: hw/bcp_sync.sv */
module bcp_sync #(
	parameter int   WIDTH     = 1,
	parameter logic RESET_VAL = 1'h1
) (
	input  wire logic             clk_in,
	input  wire logic             reset_n_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// stage1 is read only by the second flop
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stage1   <= {WIDTH{RESET_VAL}};
			sync_out <= {WIDTH{RESET_VAL}};
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

/* File: hw/bcp_top.sv */
module bcp_top
	import bcp_pkg::*;
(
	input  wire logic                        clk_in,
	input  wire logic                        reset_n_in,
	input  wire logic                        idle_insert_select_in,
	input  wire logic                        boot_byte_width_strap_n_in,
	input  wire logic                        boot_half_width_strap_n_in,
	input  wire logic                        external_cacheability_pin_in,
	input  wire logic                        wake_request_n_in,
	input  wire logic                        float_n_in,
	input  wire bcp_pkg::bcp_req_t           req_in,
	input  wire logic                        done_in,
	input  wire logic                        sleep_req_in,
	input  wire bcp_pkg::bcp_cache_ctrl_t    cache_ctrl_in,
	input  wire bcp_pkg::bcp_region_widths_t region_widths_in,
	output logic                             bus_start_out,
	output logic                             idle_gap_out,
	output logic                             addr_only_out,
	output bcp_pkg::bcp_width_t              access_width_out,
	output bcp_pkg::bcp_width_t              boot_width_out,
	output logic                             cacheable_out,
	output logic                             cacheable_valid_out,
	output logic                             sleep_indicator_n_out,
	output logic                             sleep_indicator_oe_out,
	output logic                             pins_oe_out
);
	import bcp_pkg::*;

	default clocking bcp_cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);

	typedef enum logic [1:0] {
		BCP_ST_READY,
		BCP_ST_IDLE_GAP,
		BCP_ST_ADDR_GAP,
		BCP_ST_BUSY
	} bcp_state_t;

	logic       idle_sel;
	logic       byte_n;
	logic       half_n;
	logic       cache_pin;
	logic       wake_n;
	logic       float_n;

	// the six pins in u_sync pass two flops, done_in does not; wake is the one that really needs it
	bcp_sync #(
		.WIDTH     (6),
		.RESET_VAL (BCP_SYNC_HIGH_RST)
	) u_sync (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.async_in   ({idle_insert_select_in, boot_byte_width_strap_n_in,
		              boot_half_width_strap_n_in,
		              external_cacheability_pin_in, wake_request_n_in,
		              float_n_in}),
		.sync_out   ({idle_sel, byte_n, half_n, cache_pin, wake_n,
		              float_n})
	);

	function automatic bcp_width_t region_width(
		input logic [2:0]         region,
		input bcp_width_t         boot,
		input bcp_region_widths_t table_w
	);
		if (region == BCP_REGION_BOOT)
			return boot;
		else if (region > BCP_REGION_LAST)
			return BCP_WIDTH_32;
		else
			return table_w[region];
	endfunction

	// strap capture
	logic [1:0] cap_cnt;
	logic [1:0] next_cap_cnt;
	bcp_width_t boot_width;
	bcp_width_t next_boot_width;

	always_comb begin
		next_cap_cnt    = cap_cnt;
		next_boot_width = boot_width;
		if (cap_cnt != BCP_STRAP_DONE)
			next_cap_cnt = cap_cnt + 2'h1;
		if (cap_cnt == BCP_STRAP_TAKE) begin
			if (!byte_n)
				next_boot_width = BCP_WIDTH_8;
			else if (!half_n)
				next_boot_width = BCP_WIDTH_16;
			else
				next_boot_width = BCP_WIDTH_32;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cap_cnt    <= 2'h0;
			boot_width <= BCP_BOOT_WIDTH_RST;
		end else begin
			cap_cnt    <= next_cap_cnt;
			boot_width <= next_boot_width;
		end
	end

	// bus cycle sequencer and sleep
	bcp_state_t state;
	bcp_state_t next_state;
	bcp_req_t   cur;
	bcp_req_t   next_cur;
	logic [1:0] gap_cnt;
	logic [1:0] next_gap_cnt;
	logic       last_boot_ls;
	logic       next_last_boot_ls;
	logic       last_read;
	logic       next_last_read;
	logic       sleep;
	logic       next_sleep;
	logic       launch;
	bcp_width_t next_width;

	always_comb begin
		next_state        = state;
		next_cur          = cur;
		next_gap_cnt      = gap_cnt;
		next_last_boot_ls = last_boot_ls;
		next_last_read    = last_read;
		next_sleep        = sleep;
		launch            = 1'b0;
		case (state)
			BCP_ST_READY: begin
				// sleep is entered only between bus cycles
				if (sleep) begin
					if (!wake_n)
						next_sleep = 1'b0;
				end else if (sleep_req_in) begin
					next_sleep = 1'b1;
				end else if (req_in.valid) begin
					next_cur = req_in;
					if (idle_sel && last_boot_ls) begin
						next_state   = BCP_ST_IDLE_GAP;
						next_gap_cnt = BCP_IDLE_LOAD;
					end else if (!idle_sel && last_read && req_in.write) begin
						next_state = BCP_ST_ADDR_GAP;
					end else begin
						next_state = BCP_ST_BUSY;
						launch     = 1'b1;
					end
				end
			end
			BCP_ST_IDLE_GAP: begin
				if (gap_cnt == 2'h0) begin
					next_state = BCP_ST_BUSY;
					launch     = 1'b1;
				end else begin
					next_gap_cnt = gap_cnt - 2'h1;
				end
			end
			BCP_ST_ADDR_GAP: begin
				next_state = BCP_ST_BUSY;
				launch     = 1'b1;
			end
			BCP_ST_BUSY: begin
				if (done_in) begin
					next_state        = BCP_ST_READY;
					next_last_boot_ls = !cur.fetch &&
					                    cur.region == BCP_REGION_BOOT;
					next_last_read    = !cur.write;
				end
			end
			default: next_state = BCP_ST_READY;
		endcase
		next_width = launch ? region_width(next_cur.region, boot_width,
		                                   region_widths_in)
		                    : access_width_out;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state            <= BCP_ST_READY;
			cur              <= '0;
			gap_cnt          <= 2'h0;
			last_boot_ls     <= 1'b0;
			last_read        <= 1'b0;
			sleep            <= 1'b0;
			bus_start_out    <= 1'b0;
			idle_gap_out     <= 1'b0;
			addr_only_out    <= 1'b0;
			access_width_out <= BCP_WIDTH_32;
		end else begin
			state            <= next_state;
			cur              <= next_cur;
			gap_cnt          <= next_gap_cnt;
			last_boot_ls     <= next_last_boot_ls;
			last_read        <= next_last_read;
			sleep            <= next_sleep;
			bus_start_out    <= launch;
			idle_gap_out     <= next_state == BCP_ST_IDLE_GAP;
			addr_only_out    <= next_state == BCP_ST_ADDR_GAP;
			access_width_out <= next_width;
		end
	end

	// cacheability qualification
	logic       c_busy;
	logic       next_c_busy;
	logic [1:0] c_cnt;
	logic [1:0] next_c_cnt;
	logic       next_cacheable;
	logic       next_c_valid;
	logic       honour;

	assign honour = cache_ctrl_in.cache_enable && !cache_ctrl_in.internal_sel
	                && !next_cur.fetch;

	always_comb begin
		next_c_busy    = c_busy;
		next_c_cnt     = c_cnt;
		next_cacheable = cacheable_out;
		next_c_valid   = 1'b0;
		if (c_busy) begin
			if (c_cnt == 2'h0) begin
				next_cacheable = cache_pin;
				next_c_valid   = 1'b1;
				next_c_busy    = 1'b0;
			end else begin
				next_c_cnt = c_cnt - 2'h1;
			end
		end else if (launch) begin
			if (honour) begin
				next_c_busy = 1'b1;
				next_c_cnt  = cache_ctrl_in.nc_wait;
			end else begin
				next_cacheable = next_cur.internal_cacheable;
				next_c_valid   = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			c_busy                 <= 1'b0;
			c_cnt                  <= 2'h0;
			cacheable_out          <= 1'b0;
			cacheable_valid_out    <= 1'b0;
			sleep_indicator_n_out  <= 1'b1;
			sleep_indicator_oe_out <= 1'b1;
			pins_oe_out            <= 1'b1;
			boot_width_out         <= BCP_BOOT_WIDTH_RST;
		end else begin
			c_busy                 <= next_c_busy;
			c_cnt                  <= next_c_cnt;
			cacheable_out          <= next_cacheable;
			cacheable_valid_out    <= next_c_valid;
			sleep_indicator_n_out  <= !next_sleep;
			sleep_indicator_oe_out <= float_n;
			pins_oe_out            <= float_n;
			boot_width_out         <= next_boot_width;
		end
	end

	// checks
	idle_gap_two_a: assert property (
		$rose(idle_gap_out) |-> idle_gap_out [*2] ##1
		(!idle_gap_out && bus_start_out))
		else $error("idle gap is not two clocks");

	addr_gap_one_a: assert property (
		addr_only_out |=> !addr_only_out && bus_start_out)
		else $error("address-only gap is not one clock");

	addr_gap_cause_a: assert property (
		$rose(addr_only_out) |-> $past(last_read) && cur.write
		&& !$past(idle_sel))
		else $error("address-only clock without read then write");

	strap_width_a: assert property (
		cap_cnt == BCP_STRAP_TAKE && !byte_n |=>
		(boot_width == BCP_WIDTH_8) [*2])
		else $error("byte strap did not select 8 bits");

	strap_hold_a: assert property (
		cap_cnt == BCP_STRAP_DONE |=> $stable(boot_width))
		else $error("boot width changed after capture");

	region_width_a: assert property (
		launch && next_cur.region != BCP_REGION_BOOT &&
		next_cur.region <= BCP_REGION_LAST |=>
		access_width_out == $past(region_widths_in[next_cur.region]))
		else $error("region width not taken from control word");

	fetch_ignore_a: assert property (
		launch && next_cur.fetch |=> cacheable_valid_out &&
		cacheable_out == $past(next_cur.internal_cacheable))
		else $error("pin used for an instruction fetch");

	cache_wait_a: assert property (
		launch && honour && cache_ctrl_in.nc_wait == 2'h2 |=>
		!cacheable_valid_out [*3] ##1 cacheable_valid_out)
		else $error("pin sampled at the wrong clock");

	sleep_out_a: assert property (
		sleep |-> !sleep_indicator_n_out)
		else $error("sleep indicator high while asleep");

	// the indicator must rise on the very next edge, not merely later
	wake_exit_a: assert property (
		sleep && state == BCP_ST_READY && !wake_n |=>
		sleep_indicator_n_out)
		else $error("wake request did not end sleep");

	float_a: assert property (
		!float_n |=> !pins_oe_out && !sleep_indicator_oe_out)
		else $error("pins driven while floated");

	idle_cov: cover property ($rose(idle_gap_out));
	addr_cov: cover property (addr_only_out);
	wait_cov: cover property (cacheable_valid_out && $past(c_busy, 2));
	wake_cov: cover property ($rose(sleep_indicator_n_out));
endmodule

/* File: test/bcp_far_model.sv */
module bcp_far_model (
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	input  wire logic bus_start_in,
	input  wire logic slow_in,
	input  wire logic sleep_n_in,
	input  wire logic wake_go_in,
	output logic      done_out,
	output logic      wake_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// slow answers leave room for a late cacheability sample
	int cnt;
	int wcnt;
	assign wake_n_out = (wcnt == 0);
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt <= 0;
			wcnt <= 0;
			done_out <= 1'h0;
		end else begin
			done_out <= (bus_start_in && !slow_in) || cnt == 1;
			if (bus_start_in && slow_in) begin
				cnt <= 6;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
			// three clocks low, begun only while the indicator shows sleep
			if (wcnt != 0) begin
				wcnt <= wcnt - 1;
			end else if (wake_go_in && !sleep_n_in) begin
				wcnt <= 3;
			end
		end
	end
endmodule

/* File: test/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import bcp_pkg::*;
	typedef struct packed {
		logic            idle;
		bcp_req_t        r;
		bcp_cache_ctrl_t c;
		logic            pin;
		logic [1:0]      gap;
	} bcp_row_t;
	// gap 2 idle clocks, 1 address clock; row 8 follows a boot fetch,
	// which must not arm the idle gap
	localparam bcp_row_t ROWS [11] = '{
		'{1'h0, 7'h41, 4'h0, 1'h0, 2'h0}, '{1'h0, 7'h62, 4'h8, 1'h0, 2'h1},
		'{1'h0, 7'h64, 4'hA, 1'h1, 2'h0}, '{1'h0, 7'h46, 4'hE, 1'h0, 2'h0},
		'{1'h0, 7'h4A, 4'h9, 1'h1, 2'h0}, '{1'h1, 7'h40, 4'hC, 1'h1, 2'h0},
		'{1'h1, 7'h62, 4'h8, 1'h0, 2'h2}, '{1'h1, 7'h51, 4'h8, 1'h0, 2'h0},
		'{1'h1, 7'h68, 4'h0, 1'h0, 2'h0}, '{1'h1, 7'h40, 4'h0, 1'h0, 2'h0},
		'{1'h0, 7'h65, 4'h0, 1'h0, 2'h1}
	};
	logic               clk_in, reset_n_in, idle_sel, byte_n, half_n;
	logic               cpin, wake_n, float_n, done_in, sleep_req;
	logic               slow, wake_go, cv, hon;
	logic               bus_start_out, idle_gap_out, addr_only_out;
	logic               cacheable_out, cacheable_valid_out, pins_oe_out;
	logic               sleep_indicator_n_out, sleep_indicator_oe_out;
	bcp_req_t           req_in;
	bcp_cache_ctrl_t    ctl;
	bcp_region_widths_t rw;
	bcp_width_t         access_width_out, boot_width_out, w, bw;
	bcp_row_t           rr;
	int                 errors, samples_checked, ig, ao, lat, clat, n;

	bcp_top dut (
		.clk_in(clk_in), .reset_n_in(reset_n_in),
		.idle_insert_select_in(idle_sel),
		.boot_byte_width_strap_n_in(byte_n),
		.boot_half_width_strap_n_in(half_n),
		.external_cacheability_pin_in(cpin),
		.wake_request_n_in(wake_n), .float_n_in(float_n),
		.req_in(req_in), .done_in(done_in), .sleep_req_in(sleep_req),
		.cache_ctrl_in(ctl), .region_widths_in(rw),
		.bus_start_out(bus_start_out), .idle_gap_out(idle_gap_out),
		.addr_only_out(addr_only_out), .access_width_out(access_width_out),
		.boot_width_out(boot_width_out), .cacheable_out(cacheable_out),
		.cacheable_valid_out(cacheable_valid_out),
		.sleep_indicator_n_out(sleep_indicator_n_out),
		.sleep_indicator_oe_out(sleep_indicator_oe_out),
		.pins_oe_out(pins_oe_out)
	);
	bcp_far_model partner (
		.clk_in(clk_in), .reset_n_in(reset_n_in),
		.bus_start_in(bus_start_out), .slow_in(slow),
		.sleep_n_in(sleep_indicator_n_out), .wake_go_in(wake_go),
		.done_out(done_in), .wake_n_out(wake_n)
	);

	initial begin
		clk_in = 1'h0;
		forever #5 clk_in = ~clk_in;
	end

	task automatic check(input string what, input logic [7:0] exp,
			input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	function automatic bcp_width_t exp_w(input logic [2:0] r);
		return (r == BCP_REGION_BOOT) ? bw : rw[r];
	endfunction

	task automatic do_reset(input logic b8_n, input logic b16_n);
		@(posedge clk_in);
		reset_n_in <= 1'h0;
		byte_n <= b8_n;
		half_n <= b16_n;
		repeat (16) @(posedge clk_in);
		reset_n_in <= 1'h1;
		repeat (4) @(posedge clk_in);
	endtask

	// holds the request until the start, then waits for the far side's done
	task automatic run(input bcp_req_t r);
		lat = 0;
		clat = -1;
		cv = 1'hx;
		w = 'x;
		ig = 0;
		ao = 0;
		@(posedge clk_in);
		req_in <= r;
		for (int k = 1; k < 40; k++) begin
			@(posedge clk_in);
			if (lat != 0) req_in.valid <= 1'h0;
			#1;
			ig += (idle_gap_out === 1'h1);
			ao += (addr_only_out === 1'h1);
			if (lat == 0 && bus_start_out === 1'h1) begin
				lat = k;
				w = access_width_out;
			end
			if (lat != 0 && clat < 0 && cacheable_valid_out === 1'h1) begin
				clat = k - lat;
				cv = cacheable_out;
			end
			if (done_in === 1'h1) break;
		end
		@(posedge clk_in);
	endtask

	initial begin
		errors = 0;
		samples_checked = 0;
		reset_n_in = 1'h0;
		{idle_sel, cpin, sleep_req, slow, wake_go} = 5'h00;
		{byte_n, half_n, float_n} = 3'h7;
		req_in = '0;
		ctl = '0;
		// packed table, region 5 leftmost
		rw = {BCP_WIDTH_16, BCP_WIDTH_8, BCP_WIDTH_32,
		      BCP_WIDTH_16, BCP_WIDTH_8};
		bw = BCP_WIDTH_32;
		do_reset(1'h1, 1'h1);
		foreach (ROWS[i]) begin
			rr = ROWS[i];
			idle_sel <= rr.idle;
			ctl <= rr.c;
			cpin <= rr.pin;
			hon = rr.c.cache_enable && !rr.c.internal_sel && !rr.r.fetch;
			slow <= hon;
			repeat (3) @(posedge clk_in);
			run(rr.r);
			check("start_delay", 8'(rr.gap) + 8'h01, 8'(lat));
			check("idle_clks", (rr.gap == 2) ? 8'h02 : 8'h00, 8'(ig));
			check("addr_clks", (rr.gap == 1) ? 8'h01 : 8'h00, 8'(ao));
			check("width", 8'(exp_w(rr.r.region)), 8'(w));
			check("cache_delay", hon ? 8'(rr.c.nc_wait) + 8'h01 : 8'h00,
				8'(clat));
			check("cacheable", 8'(hon ? rr.pin : rr.r.internal_cacheable),
				8'(cv));
		end
		sleep_req <= 1'h1;
		@(posedge clk_in);
		sleep_req <= 1'h0;
		repeat (3) @(posedge clk_in);
		#1;
		check("sleep_n", 8'h00, 8'(sleep_indicator_n_out));
		check("sleep_oe", 8'h01, 8'(sleep_indicator_oe_out));
		@(posedge clk_in);
		wake_go <= 1'h1;
		@(posedge clk_in);
		wake_go <= 1'h0;
		n = 0;
		while (sleep_indicator_n_out !== 1'h1 && n < 12) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		// two sync edges, then the sleep flag clears on the third
		check("wake_delay", 8'h03, 8'(n));
		@(posedge clk_in);
		float_n <= 1'h0;
		repeat (4) @(posedge clk_in);
		#1;
		check("pins_oe", 8'h00, 8'(pins_oe_out));
		check("sleep_pin_oe", 8'h00, 8'(sleep_indicator_oe_out));
		@(posedge clk_in);
		float_n <= 1'h1;
		repeat (4) @(posedge clk_in);
		#1;
		check("pins_oe", 8'h01, 8'(pins_oe_out));
		for (int i = 0; i < 3; i++) begin
			do_reset(i != 0, i != 1);
			bw = (i == 0) ? BCP_WIDTH_8 : (i == 1) ? BCP_WIDTH_16 : BCP_WIDTH_32;
			// swapping never leaves both low; capture must ignore it
			byte_n <= half_n;
			half_n <= byte_n;
			#1;
			check("boot_width", 8'(bw), 8'(boot_width_out));
			for (int k = 0; k < 2; k++) begin
				run({1'h1, 2'h0, 3'(k), 1'h0});
				check("strap_width", 8'(exp_w(3'(k))), 8'(w));
			end
		end
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge clk_in);
		errors++;
		end_sim();
	end
endmodule
